// *** design/evct_timer.sv ***
// module: event counter/timer with prescaler, match, capture and wishbone slave
//
// Our own choices: the placing of the registers and the Wishbone slave port.

// Summary of operation
// - counter width is a parameter, instanced as 32 or 16 bits.
// - prescaler ahead of the counter, same width as the counter.
// - timer mode counts clock cycles divided by the prescaler value plus one.
// - counter mode counts edges on the external count input instead.
// - four match registers compared against the counter, each with actions.
// - a match may let the counter run on, interrupt selectable.
// - a match may stop the counter, interrupt selectable.
// - a match may return the counter to zero, interrupt selectable.
// - four match pins go low, high, toggle or hold on their match.
// - two capture channels load the counter on an input transition.
// - each capture channel may raise an interrupt.
// - a chosen capture edge may clear counter and prescaler.
module evct_timer #(
  parameter int unsigned W = 32
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire evct_pkg::evct_wbreq_t wb_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // pins
  input wire logic [evct_pkg::NCAP-1:0] cap_i,
  input wire logic cnt_i,
  output logic [evct_pkg::NMAT-1:0] match_o,
  // interrupt
  output logic irq_o
);
  import evct_pkg::*;

  // ==================================================
  // state
  evct_ctrl_t ctrl_q, ctrl_d;
  logic [W-1:0] tc_q, tc_d;
  logic [W-1:0] pr_q, pr_d;
  logic [W-1:0] pc_q, pc_d;
  logic [11:0] mcr_q, mcr_d;
  logic [W-1:0] mr_q [NMAT], mr_d [NMAT];
  logic [5:0] ccr_q, ccr_d;
  logic [W-1:0] cr_q [NCAP], cr_d [NCAP];
  logic [7:0] emc_q, emc_d;
  logic [3:0] ext_q, ext_d;
  logic [NIRQ-1:0] ir_q, ir_d;
  logic [NIRQ-1:0] imsk_q, imsk_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic irq_q, irq_d;
  logic [2:0] s1_q, s2_q, s3_q;

  // ==================================================
  // helpers
  function automatic logic [31:0] zx(input logic [W-1:0] v);
    logic [31:0] r;
    r = '0;
    r[W-1:0] = v;
    return r;
  endfunction

  function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n,
                                      input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = n[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ==================================================
  // input synchronisers: cap0, cap1, count input
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
    end else if (ce_i) begin
      s1_q <= {cnt_i, cap_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  logic [2:0] rise, fall;
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;

  // ==================================================
  // counting and match detection
  logic cnt_edge, tick, adv;
  logic [NMAT-1:0] hit, hit_rst, hit_stop, hit_int;

  always_comb begin
    unique case (ctrl_q.mode)
      MODE_TIMER: cnt_edge = 1'b1;
      MODE_RISE: cnt_edge = rise[2];
      MODE_FALL: cnt_edge = fall[2];
      MODE_BOTH: cnt_edge = rise[2] | fall[2];
    endcase
  end

  assign tick = ctrl_q.en & ~ctrl_q.crst & cnt_edge;
  assign adv = tick & (pc_q == pr_q);

  genvar gi;
  generate
    for (gi = 0; gi < NMAT; gi++) begin : g_mat
      assign hit[gi] = adv & (tc_q == mr_q[gi]);
      assign hit_int[gi] = hit[gi] & mcr_q[3*gi+MCR_INT];
      assign hit_rst[gi] = hit[gi] & mcr_q[3*gi+MCR_RST];
      assign hit_stop[gi] = hit[gi] & mcr_q[3*gi+MCR_STOP];
    end
  endgenerate

  // ==================================================
  // capture events
  logic [NCAP-1:0] cap_ev, cap_int;
  logic clr_ev;

  generate
    for (gi = 0; gi < NCAP; gi++) begin : g_cap
      assign cap_ev[gi] = (ccr_q[3*gi+CCR_RISE] & rise[gi]) |
                          (ccr_q[3*gi+CCR_FALL] & fall[gi]);
      assign cap_int[gi] = cap_ev[gi] & ccr_q[3*gi+CCR_INT];
    end
  endgenerate

  assign clr_ev = ctrl_q.cc_en &
                  ((ctrl_q.cc_edge[0] & rise[ctrl_q.cc_sel]) |
                   (ctrl_q.cc_edge[1] & fall[ctrl_q.cc_sel]));

  // ==================================================
  // bus decode
  logic acc, wr, rd;
  logic [31:0] wv;
  logic [NIRQ-1:0] ir_clr, ir_set;

  assign acc = wb_i.cyc & wb_i.stb & ~ack_q;
  assign wr = acc & wb_i.we;
  assign rd = acc & ~wb_i.we;
  assign ir_set = {cap_int, hit_int};

  // ==================================================
  // next state
  always_comb begin
    ctrl_d = ctrl_q;
    tc_d = tc_q;
    pr_d = pr_q;
    pc_d = pc_q;
    mcr_d = mcr_q;
    mr_d = mr_q;
    ccr_d = ccr_q;
    cr_d = cr_q;
    emc_d = emc_q;
    ext_d = ext_q;
    imsk_d = imsk_q;
    ir_clr = '0;
    ack_d = acc;
    rdat_d = 32'h0000_0000;
    wv = 32'h0000_0000;

    // counter and prescaler advance
    if (tick) begin
      pc_d = adv ? '0 : pc_q + 1'b1;
    end
    if (adv) begin
      tc_d = (|hit_rst) ? '0 : tc_q + 1'b1;
    end
    if (|hit_stop) begin
      ctrl_d.en = 1'b0;
    end

    // match pin actions
    for (int i = 0; i < NMAT; i++) begin
      if (hit[i]) begin
        unique case (evct_ema_t'(emc_q[2*i +: 2]))
          EMA_NONE: ext_d[i] = ext_q[i];
          EMA_LOW: ext_d[i] = 1'b0;
          EMA_HIGH: ext_d[i] = 1'b1;
          EMA_TOGGLE: ext_d[i] = ~ext_q[i];
        endcase
      end
    end

    // capture loads
    for (int j = 0; j < NCAP; j++) begin
      if (cap_ev[j]) begin
        cr_d[j] = tc_q;
      end
    end

    // clear on capture, or held in reset by software
    if (clr_ev | ctrl_q.crst) begin
      tc_d = '0;
      pc_d = '0;
    end

    // register reads
    if (rd) begin
      unique case (wb_i.adr)
        OFS_CTRL: rdat_d = {24'h0, ctrl_q};
        OFS_TC: rdat_d = zx(tc_q);
        OFS_PR: rdat_d = zx(pr_q);
        OFS_PC: rdat_d = zx(pc_q);
        OFS_MCR: rdat_d = {20'h0, mcr_q};
        OFS_MR0: rdat_d = zx(mr_q[0]);
        OFS_MR0 + 8'h04: rdat_d = zx(mr_q[1]);
        OFS_MR0 + 8'h08: rdat_d = zx(mr_q[2]);
        OFS_MR0 + 8'h0c: rdat_d = zx(mr_q[3]);
        OFS_CCR: rdat_d = {26'h0, ccr_q};
        OFS_CR0: rdat_d = zx(cr_q[0]);
        OFS_CR0 + 8'h04: rdat_d = zx(cr_q[1]);
        OFS_EMR: rdat_d = {20'h0, emc_q, ext_q};
        OFS_IR: begin
          rdat_d = {26'h0, ir_q};
          ir_clr = '1;
        end
        OFS_IMSK: rdat_d = {26'h0, imsk_q};
        default: rdat_d = 32'h0000_0000;
      endcase
    end

    // register writes
    if (wr) begin
      unique case (wb_i.adr)
        OFS_CTRL: begin
          wv = mrg({24'h0, ctrl_q}, wb_i.dat, wb_i.sel);
          ctrl_d = evct_ctrl_t'(wv[7:0]);
        end
        OFS_TC: begin
          wv = mrg(zx(tc_q), wb_i.dat, wb_i.sel);
          tc_d = wv[W-1:0];
        end
        OFS_PR: begin
          wv = mrg(zx(pr_q), wb_i.dat, wb_i.sel);
          pr_d = wv[W-1:0];
        end
        OFS_PC: begin
          wv = mrg(zx(pc_q), wb_i.dat, wb_i.sel);
          pc_d = wv[W-1:0];
        end
        OFS_MCR: begin
          wv = mrg({20'h0, mcr_q}, wb_i.dat, wb_i.sel);
          mcr_d = wv[11:0];
        end
        OFS_MR0, OFS_MR0 + 8'h04, OFS_MR0 + 8'h08, OFS_MR0 + 8'h0c: begin
          wv = mrg(zx(mr_q[wb_i.adr[3:2] - 2'd1]), wb_i.dat, wb_i.sel);
          mr_d[wb_i.adr[3:2] - 2'd1] = wv[W-1:0];
        end
        OFS_CCR: begin
          wv = mrg({26'h0, ccr_q}, wb_i.dat, wb_i.sel);
          ccr_d = wv[5:0];
        end
        OFS_EMR: begin
          wv = mrg({20'h0, emc_q, ext_q}, wb_i.dat, wb_i.sel);
          emc_d = wv[11:4];
          ext_d = wv[3:0];
        end
        OFS_IR: begin
          wv = mrg(32'h0, wb_i.dat, wb_i.sel);
          ir_clr = wv[NIRQ-1:0];
        end
        OFS_IMSK: begin
          wv = mrg({26'h0, imsk_q}, wb_i.dat, wb_i.sel);
          imsk_d = wv[NIRQ-1:0];
        end
        default: wv = 32'h0000_0000;
      endcase
    end

    // pending flags: a new event wins over a clear
    ir_d = (ir_q & ~ir_clr) | ir_set;
    irq_d = |(ir_d & imsk_d);
  end

  // ==================================================
  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= RST_CTRL;
      tc_q <= '0;
      pr_q <= '0;
      pc_q <= '0;
      mcr_q <= RST_MCR;
      ccr_q <= RST_CCR;
      emc_q <= RST_EMC;
      ext_q <= RST_EXT;
      ir_q <= '0;
      imsk_q <= RST_IMSK;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      irq_q <= 1'b0;
      for (int i = 0; i < NMAT; i++) begin
        mr_q[i] <= '0;
      end
      for (int j = 0; j < NCAP; j++) begin
        cr_q[j] <= '0;
      end
    end else if (ce_i) begin
      ctrl_q <= ctrl_d;
      tc_q <= tc_d;
      pr_q <= pr_d;
      pc_q <= pc_d;
      mcr_q <= mcr_d;
      ccr_q <= ccr_d;
      emc_q <= emc_d;
      ext_q <= ext_d;
      ir_q <= ir_d;
      imsk_q <= imsk_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      irq_q <= irq_d;
      mr_q <= mr_d;
      cr_q <= cr_d;
    end
  end

  // ==================================================
  // outputs
  assign dat_o = rdat_q;
  assign ack_o = ack_q;
  assign match_o = ext_q;
  assign irq_o = irq_q;

endmodule // evct_timer

// *** inc/evct_pkg.sv ***
// package: register map, field layout and types of the event counter/timer
package evct_pkg;

  // ==================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TC = 8'h04;
  localparam logic [7:0] OFS_PR = 8'h08;
  localparam logic [7:0] OFS_PC = 8'h0c;
  localparam logic [7:0] OFS_MCR = 8'h10;
  localparam logic [7:0] OFS_MR0 = 8'h14;
  localparam logic [7:0] OFS_CCR = 8'h24;
  localparam logic [7:0] OFS_CR0 = 8'h28;
  localparam logic [7:0] OFS_EMR = 8'h30;
  localparam logic [7:0] OFS_IR = 8'h34;
  localparam logic [7:0] OFS_IMSK = 8'h38;

  // ==================================================
  // counts and field positions
  localparam int NMAT = 4;
  localparam int NCAP = 2;
  localparam int NIRQ = 6;
  localparam int MCR_INT = 0;
  localparam int MCR_RST = 1;
  localparam int MCR_STOP = 2;
  localparam int CCR_RISE = 0;
  localparam int CCR_FALL = 1;
  localparam int CCR_INT = 2;
  localparam int IR_CAP0 = 4;

  // ==================================================
  // reset values
  localparam logic [11:0] RST_MCR = 12'h000;
  localparam logic [5:0] RST_CCR = 6'h00;
  localparam logic [7:0] RST_EMC = 8'h00;
  localparam logic [3:0] RST_EXT = 4'h0;
  localparam logic [5:0] RST_IMSK = 6'h00;

  // ==================================================
  // types
  typedef enum logic [1:0] {
    MODE_TIMER = 2'b00,
    MODE_RISE = 2'b01,
    MODE_FALL = 2'b10,
    MODE_BOTH = 2'b11
  } evct_mode_t;

  typedef enum logic [1:0] {
    EMA_NONE = 2'b00,
    EMA_LOW = 2'b01,
    EMA_HIGH = 2'b10,
    EMA_TOGGLE = 2'b11
  } evct_ema_t;

  typedef struct packed {
    logic [1:0] cc_edge;
    logic cc_sel;
    logic cc_en;
    evct_mode_t mode;
    logic crst;
    logic en;
  } evct_ctrl_t;

  localparam evct_ctrl_t RST_CTRL = '{2'b00, 1'b0, 1'b0, MODE_TIMER, 1'b0, 1'b0};

  typedef struct packed {
    logic [7:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
    logic cyc;
    logic stb;
  } evct_wbreq_t;

endpackage

// *** tb/evct_assertions.sv ***
// checker: bus handshake, reset and freeze properties of evct_timer
module evct_assertions #(
  parameter int unsigned W = 32
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // bus
  input wire evct_pkg::evct_wbreq_t wb_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // pins, interrupt
  input wire logic [evct_pkg::NMAT-1:0] match_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import evct_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==================================================
  // assertions
  a_ack_taken:
    assert property (wb_i.cyc && wb_i.stb && !ack_o && ce_i |=> ack_o) else $error("no ack");
  a_ack_drop:
    assert property (ack_o && ce_i |=> !ack_o) else $error("ack too long");
  a_ack_cause:
    assert property ($rose(ack_o) |-> $past(wb_i.cyc && wb_i.stb)) else $error("stray ack");
  a_dat_idle:
    assert property (!ack_o |-> dat_o == '0) else $error("data without ack");
  a_rst_quiet:
    assert property (disable iff (1'b0) rst_i && ce_i |=> !ack_o && !irq_o && match_o == '0)
    else $error("outputs not cleared");
  a_ce_freeze:
    assert property (!ce_i |=> $stable(match_o) && $stable(irq_o) && $stable(ack_o))
    else $error("moved while frozen");
  a_unmapped_zero:
    assert property ($rose(ack_o) && $past(!wb_i.we && wb_i.adr >= 8'h3c) |-> dat_o == '0)
    else $error("unmapped read not zero");
  a_tc_width:
    assert property ($rose(ack_o) && $past(!wb_i.we && wb_i.adr == OFS_TC) |-> (dat_o >> W) == '0)
    else $error("counter wider than set");
  c_irq: cover property ($rose(irq_o));
  c_pin: cover property ($changed(match_o));
  c_wr: cover property (ack_o && $past(wb_i.we));
endmodule // evct_assertions

bind evct_timer evct_assertions #(.W(W)) evct_assertions_inst (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .wb_i(wb_i), .dat_o(dat_o), .ack_o(ack_o), .match_o(match_o), .irq_o(irq_o));

// *** tb/evct_pins.sv ***
// far-side pin model: capture and count inputs
module evct_pins (
  // clock
  input wire logic clk_i,
  // pins: capture 1:0, count 2
  output logic [2:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pin_o = 3'h0;
  // ==================================================
  // one high pulse of n cycles, then idle
  task automatic pulse(input int k, input int n);
    pin_o[k] <= 1'b1;
    repeat (n) @(posedge clk_i);
    pin_o[k] <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask
endmodule // evct_pins

// *** tb/testbench.sv ***
// testbench: bus, timer, match pin, capture and count scenarios
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import evct_pkg::*;
  // ==================================================
  // signals
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  evct_wbreq_t wb_i = '0;
  logic [31:0] dat_o, r, v;
  logic ack_o, irq_o;
  logic [3:0] match_o;
  logic [2:0] pin;
  logic [7:0] ofs [8] = '{OFS_CTRL, OFS_TC, OFS_PR, OFS_MCR, OFS_CCR, OFS_CR0, OFS_IR, 8'h40};
  int num_errors = 0;
  int tests_run = 0;
  int m, p;
  always #20 clk_i = ~clk_i;
  evct_timer #(.W(16)) evct_timer_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_i(wb_i), .dat_o(dat_o), .ack_o(ack_o), .cap_i(pin[1:0]), .cnt_i(pin[2]),
    .match_o(match_o), .irq_o(irq_o));
  evct_pins evct_pins_inst (.clk_i(clk_i), .pin_o(pin));
  // ==================================================
  // tasks and expectations
  task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
    wb_i <= '{a, d, 4'hf, we, 1'b1, 1'b1};
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    r = dat_o;
    wb_i <= '0;
    @(posedge clk_i);
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, s, e);
    end
  endtask
  function automatic logic pin_exp(input logic [1:0] a, input logic s);
    case (a)
      2'h1: return 1'b0;
      2'h2: return 1'b1;
      2'h3: return ~s;
      default: return s;
    endcase
  endfunction
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==================================================
  // main sequence
  initial begin
    r = $urandom(32'hb76afa93);
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(8'h40, 1'b1, 32'hffff);
    wb(OFS_CR0, 1'b1, 32'h1234);
    foreach (ofs[i]) begin
      wb(ofs[i], 1'b0, 32'h0);
      chk(r, 32'h0);
    end
    $display("register test done");
    for (int i = 0; i < 4; i++) begin
      m = 2 + $urandom_range(6);
      p = $urandom_range(3);
      wb(OFS_PR, 1'b1, 32'(p));
      wb(OFS_TC, 1'b1, 32'h0);
      wb(OFS_MR0, 1'b1, 32'(m));
      wb(OFS_MR0 + 8'h04, 1'b1, 32'((i % 3 == 2) ? m + 2 : m));
      wb(OFS_MCR, 1'b1, (i % 3 == 0) ? 32'h005 : (i % 3 == 1) ? 32'h023 : 32'h021);
      wb(OFS_EMR, 1'b1, 32'(i * 16 + i % 2));
      wb(OFS_IMSK, 1'b1, (i == 3) ? 32'h0 : 32'h1);
      wb(OFS_CTRL, 1'b1, 32'h1);
      ce_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      ce_i <= 1'b1;
      repeat ((m + 4) * (p + 1) + 12) @(posedge clk_i);
      chk(irq_o, i != 3);
      chk(match_o[0], pin_exp(i[1:0], i[0]));
      wb(OFS_TC, 1'b0, 32'h0);
      chk(r, 32'((i % 3 == 1) ? 0 : (i % 3 == 2) ? m + 3 : m + 1));
      wb(OFS_CTRL, 1'b0, 32'h0);
      chk(r, 32'h0);
      wb(OFS_IR, 1'b0, 32'h0);
      chk(r, 32'h1);
      chk(irq_o, 1'b0);
      $display("match test %0d done", i);
    end
    v = $urandom & 32'hffff;
    wb(OFS_CCR, 1'b1, 32'h05);
    wb(OFS_TC, 1'b1, v);
    wb(OFS_IMSK, 1'b1, 32'h10);
    evct_pins_inst.pulse(0, 3);
    wb(OFS_CR0, 1'b0, 32'h0);
    chk(r, v);
    chk(irq_o, 1'b1);
    wb(OFS_IR, 1'b0, 32'h0);
    chk(r, 32'h10);
    wb(OFS_CTRL, 1'b1, 32'h50);
    wb(OFS_PC, 1'b1, 32'h1);
    evct_pins_inst.pulse(0, 3);
    wb(OFS_TC, 1'b0, 32'h0);
    chk(r, 32'h0);
    wb(OFS_PC, 1'b0, 32'h0);
    chk(r, 32'h0);
    v = $urandom & 32'hffff;
    wb(OFS_CTRL, 1'b1, 32'h0);
    wb(OFS_IR, 1'b0, 32'h0);
    chk(r, 32'h10);
    wb(OFS_CCR, 1'b1, 32'h10);
    wb(OFS_TC, 1'b1, v);
    evct_pins_inst.pulse(1, 3);
    wb(OFS_CR0 + 8'h04, 1'b0, 32'h0);
    chk(r, v);
    wb(OFS_IR, 1'b0, 32'h0);
    chk(r, 32'h0);
    chk(irq_o, 1'b0);
    $display("capture test done");
    m = 1 + $urandom_range(4);
    wb(OFS_PR, 1'b1, 32'h0);
    wb(OFS_MCR, 1'b1, 32'h0);
    wb(OFS_CTRL, 1'b1, 32'h05);
    wb(OFS_TC, 1'b1, 32'h0);
    repeat (m) evct_pins_inst.pulse(2, 2);
    wb(OFS_CTRL, 1'b1, 32'h0);
    wb(OFS_TC, 1'b0, 32'h0);
    chk(r, 32'(m));
    $display("count test done");
    wb(OFS_EMR, 1'b1, 32'hf);
    chk({28'h0, match_o}, 32'hf);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({28'h0, match_o}, 32'h0);
    wb(OFS_EMR, 1'b0, 32'h0);
    chk(r, 32'h0);
    wb(OFS_CR0 + 8'h04, 1'b0, 32'h0);
    chk(r, 32'h0);
    $display("reset test done");
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    $display("CHECK FAILED t=%0t run too long", $time);
    stop_test();
  end
endmodule // testbench
